// [hdl/ucsc_pkg.sv]
// shared constants for one serial channel: register map, fields, timing
// assumes an 8-bit host port with 3 address lines, synchronous to clk
package ucsc_pkg;
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_ISR_FCR = 3'h2;
	localparam logic [2:0] ADDR_LCR = 3'h3;
	localparam logic [2:0] ADDR_MCR = 3'h4;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_FEAT = 3'h7;
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int FCR_TRIG_LO = 6;
	localparam int LCR_STOP = 2;
	localparam int LCR_PAR = 3;
	localparam int LCR_EVEN = 4;
	localparam int LCR_DLAB = 7;
	localparam int MCR_PRESC = 7;
	localparam int FEAT_HDX = 3;
	localparam int TAG_LO = 8;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] DLL_RST = 8'h01;
	localparam logic [7:0] ISR_NONE = 8'h01;
	localparam logic [7:0] ISR_THR = 8'h02;
	localparam logic [7:0] ISR_RXRDY = 8'h04;
	localparam logic [7:0] ISR_TMO = 8'h0c;
	localparam logic [1:0] ISR_FIFO_ON = 2'h3;
	localparam logic [3:0] SUB_LAST = 4'hf;
	localparam logic [3:0] HALF_LAST = 4'h7;
	localparam logic [1:0] PRESC_LAST = 2'h3;
	localparam logic [2:0] DATA_LAST_MIN = 3'h4;
	localparam logic [2:0] DATA_LAST_MAX = 3'h7;
	localparam logic [3:0] CHAR_BITS_MIN = 4'h7;
	localparam int SAMPLES = 16;
	localparam int TMO_CHARS = 4;
	localparam int TMO_EXTRA = 12;
	localparam logic [7:0] RX_TRIG0 = 8'h08;
	localparam logic [7:0] RX_TRIG1 = 8'h10;
	localparam logic [7:0] RX_TRIG2 = 8'h38;
	localparam logic [7:0] RX_TRIG3 = 8'h3c;
	localparam logic [7:0] TX_TRIG0 = 8'h08;
	localparam logic [7:0] TX_TRIG1 = 8'h10;
	localparam logic [7:0] TX_TRIG2 = 8'h20;
	localparam logic [7:0] TX_TRIG3 = 8'h38;
	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_START = 3'b001,
		SER_DATA = 3'b010,
		SER_PARITY = 3'b011,
		SER_STOP = 3'b100
	} ucsc_ser_e;
endpackage

// [hdl/ucsc_channel.sv]
// one serial channel: host port, prescaler, 16x rate generator, tx/rx fifos
// assumes host strobes synchronous to clk; clk also acts as oscillator
//
// Contract
// - no fifo: irq low while byte held, high when empty (hdx: tx idle)
// - fifo: tx irq low above trigger, high below it or empty
// - fifo: rx irq high once fill reaches trigger, low below
// - half-duplex mode off after reset, on via feature bit 3
// - prescaler divides clock by 1, or by 4 when modem bit 7 set
// - 16-bit divisor 1..65535 makes the 16x sampling tick
// - divisor split into high and low byte registers
// - each transmitted bit lasts exactly sixteen sampling ticks
// - frame: start, data lsb first, optional parity, stop bits
// - fifo mode: each holding-port write enters 128-byte tx fifo, dropped when full
// - no fifo: holding-empty set on move to shifter, tx irq source
// - fifo mode: holding-empty set whenever tx fifo empty
// - fifo mode: tx irq when fill drops below trigger, if enabled
// - tx-empty bit only when shifter idle and, in fifo mode, fifo empty
// - start edge: wait 8 ticks, accept only if line still low
// - sample data, parity, stop at centres, flag errors
// - rx fifo 128 x 11 bits, oldest entry on receive port
// - reading receive port pops and shows next entry's error tags
// - data-ready irq per character or at trigger level
// - timeout irq after 4 characters plus 12 bits of silence
// - host access needs no rate tick running
`timescale 1ns/1ps
module ucsc_channel
	import ucsc_pkg::*;
#(
	parameter int FIFO_DEPTH = 128
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic cs,
	input wire logic rd,
	input wire logic wr,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	input wire logic rxd,
	output logic txd,
	output logic irqOut
);
	localparam int PW = $clog2(FIFO_DEPTH);
	generate
		if (FIFO_DEPTH < 64 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad
			$error("FIFO_DEPTH must be a power of two, 64 or more");
		end
	endgenerate

	function automatic logic [7:0] trigLevel(input logic [1:0] sel,
		input logic rxSide);
		logic [7:0] lvl;
		lvl = TX_TRIG0;
		case (sel)
			2'h0: lvl = rxSide ? RX_TRIG0 : TX_TRIG0;
			2'h1: lvl = rxSide ? RX_TRIG1 : TX_TRIG1;
			2'h2: lvl = rxSide ? RX_TRIG2 : TX_TRIG2;
			default: lvl = rxSide ? RX_TRIG3 : TX_TRIG3;
		endcase
		return lvl;
	endfunction

	logic [1:0] ierReg;
	logic fifoEnReg;
	logic [1:0] trigSelReg;
	logic [7:0] lcrReg, mcrReg, dllReg, dlhReg, featReg;
	logic [7:0] txMem [FIFO_DEPTH];
	logic [10:0] rxMem [FIFO_DEPTH];
	logic [PW-1:0] txWp_reg, txRp_reg, rxWp_reg, rxRp_reg;
	logic [PW:0] txCount_reg, rxCount_reg;
	logic [1:0] presCnt_reg;
	logic [15:0] baudCnt_reg;
	ucsc_ser_e txState_reg, txState_next, rxState_reg, rxState_next;
	logic [3:0] txSub_reg, txSub_next, rxSub_reg, rxSub_next;
	logic [2:0] txBit_reg, txBit_next, rxBit_reg, rxBit_next;
	logic [7:0] txShift_reg, txShift_next, rxShift_reg, rxShift_next;
	logic txPar_reg, txPar_next, rxPar_reg, rxPar_next;
	logic txStop2_reg, txStop2_next, rxPe_reg, rxPe_next, txdNext;
	logic rxPrev_reg, overrun_reg, thrIrq_reg;
	logic [11:0] tmoCnt_reg;

	// host port decode; no dependence on the rate tick
	wire acc = cs & ce;
	wire dlab = lcrReg[LCR_DLAB];
	wire thrWrite = acc & wr & (addr == ADDR_DATA) & ~dlab;
	wire rhrRead = acc & rd & (addr == ADDR_DATA) & ~dlab;
	wire isrRead = acc & rd & (addr == ADDR_ISR_FCR);
	wire lsrRead = acc & rd & (addr == ADDR_LSR);
	wire fcrWrite = acc & wr & (addr == ADDR_ISR_FCR);
	wire fifoEn = fifoEnReg;
	wire hdx = featReg[FEAT_HDX];
	wire txClr = fcrWrite & (wdata[FCR_TXRST] | (wdata[FCR_EN] != fifoEn));
	wire rxClr = fcrWrite & (wdata[FCR_RXRST] | (wdata[FCR_EN] != fifoEn));
	wire [7:0] txTrig = trigLevel(trigSelReg, 1'b0);
	wire [7:0] rxTrig = trigLevel(trigSelReg, 1'b1);
	wire [2:0] dataLast = DATA_LAST_MIN + {1'b0, lcrReg[1:0]};

	// rate generation
	wire [15:0] divisor = {dlhReg, dllReg};
	wire presBy4 = mcrReg[MCR_PRESC];
	wire preTick = ce & (~presBy4 | (presCnt_reg == PRESC_LAST));
	// divisor zero stops the tick rather than wrapping to 65536
	wire tick16 = preTick & (divisor != 16'h0000) &
		(baudCnt_reg >= divisor - 16'h0001);

	// tx fifo; non-fifo mode is a one-entry holding register
	wire txFull = fifoEn ? (int'(txCount_reg) >= FIFO_DEPTH) :
		(txCount_reg != '0);
	wire txPush = thrWrite & ~txFull;
	// load waits for a tick so the start bit lasts a full bit time
	wire txPop = tick16 & (txState_reg == SER_IDLE) & (txCount_reg != '0);
	wire txAllEmpty = (txCount_reg == '0) & (txState_reg == SER_IDLE);
	wire tsrEmpty = (txState_reg == SER_IDLE) &
		(~fifoEn | (txCount_reg == '0));
	wire txBitEnd = tick16 & (txSub_reg == SUB_LAST);
	wire thrSet = txPop & (fifoEn ? (int'(txCount_reg) == int'(txTrig)) :
		(int'(txCount_reg) == 1));

	// rx side
	wire rxBitEnd = tick16 & (rxSub_reg == SUB_LAST);
	wire rxPush = (rxState_reg == SER_STOP) & rxBitEnd;
	wire [7:0] rxData = rxShift_reg >> (DATA_LAST_MAX - dataLast);
	wire frameErr = ~rxd;
	wire breakInd = frameErr & (rxData == 8'h00);
	wire [10:0] rxEntry = {breakInd, frameErr, rxPe_reg, rxData};
	wire rxFull = fifoEn & (int'(rxCount_reg) >= FIFO_DEPTH);
	wire rxDo = rxPush & ~rxFull;
	wire rxPop = rhrRead & (rxCount_reg != '0);
	wire [PW-1:0] rxWrAddr = fifoEn ? rxWp_reg : rxRp_reg;
	wire ovrSet = rxPush & (rxFull | (~fifoEn & (rxCount_reg != '0) & ~rxPop));
	wire [2:0] headTags = (rxCount_reg != '0) ?
		rxMem[rxRp_reg][TAG_LO +: 3] : 3'h0;

	// silence timeout: 4 characters plus 12 bits, counted in 16x ticks
	wire [3:0] charBits = CHAR_BITS_MIN + {2'h0, lcrReg[1:0]} +
		{3'h0, lcrReg[LCR_PAR]} + {3'h0, lcrReg[LCR_STOP]};
	wire [11:0] tmoLimit = 12'((TMO_CHARS * int'(charBits) + TMO_EXTRA) *
		SAMPLES);
	wire tmoFlag = (tmoCnt_reg == tmoLimit) & (rxCount_reg != '0);

	// interrupt conditions
	wire txPin = fifoEn ? (int'(txCount_reg) < int'(txTrig)) :
		(hdx ? txAllEmpty : (txCount_reg == '0));
	wire rxPin = fifoEn ? (int'(rxCount_reg) >= int'(rxTrig)) :
		(rxCount_reg != '0);
	wire irqNext = (ierReg[IER_TX] & txPin) |
		(ierReg[IER_RX] & (rxPin | tmoFlag));
	wire [7:0] isrCode = (ierReg[IER_RX] & tmoFlag) ? ISR_TMO :
		(ierReg[IER_RX] & rxPin) ? ISR_RXRDY :
		(ierReg[IER_TX] & thrIrq_reg) ? ISR_THR : ISR_NONE;
	wire [7:0] isrVal = {fifoEn ? ISR_FIFO_ON : 2'h0, isrCode[5:0]};
	wire [7:0] lsrVal = {1'b0, tsrEmpty, txCount_reg == '0, headTags,
		overrun_reg, rxCount_reg != '0};
	wire [7:0] rdMux = (addr == ADDR_DATA) ? (dlab ? dllReg :
			rxMem[rxRp_reg][7:0]) :
		(addr == ADDR_IER) ? (dlab ? dlhReg : {6'h00, ierReg}) :
		(addr == ADDR_ISR_FCR) ? isrVal :
		(addr == ADDR_LCR) ? lcrReg :
		(addr == ADDR_MCR) ? mcrReg :
		(addr == ADDR_LSR) ? lsrVal :
		(addr == ADDR_FEAT) ? featReg : 8'h00;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ierReg <= 2'h0;
			fifoEnReg <= 1'b0;
			trigSelReg <= 2'h0;
			lcrReg <= REG_RST;
			mcrReg <= REG_RST;
			dllReg <= DLL_RST;
			dlhReg <= REG_RST;
			featReg <= REG_RST;
		end else if (acc & wr) begin
			case (addr)
				ADDR_DATA: if (dlab) dllReg <= wdata;
				ADDR_IER: if (dlab) dlhReg <= wdata;
					else ierReg <= wdata[1:0];
				ADDR_ISR_FCR: begin
					fifoEnReg <= wdata[FCR_EN];
					trigSelReg <= wdata[FCR_TRIG_LO +: 2];
				end
				ADDR_LCR: lcrReg <= wdata;
				ADDR_MCR: mcrReg <= wdata;
				ADDR_FEAT: featReg <= wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			presCnt_reg <= 2'h0;
			baudCnt_reg <= 16'h0000;
		end else if (ce) begin
			presCnt_reg <= presBy4 ? presCnt_reg + 2'h1 : 2'h0;
			if (tick16 | (divisor == 16'h0000))
				baudCnt_reg <= 16'h0000;
			else if (preTick)
				baudCnt_reg <= baudCnt_reg + 16'h0001;
		end
	end

	// fifo storage carries no reset; counts define what is valid
	always_ff @(posedge clk) begin
		if (ce & txPush)
			txMem[txWp_reg] <= wdata;
		if (ce & rxDo)
			rxMem[rxWrAddr] <= rxEntry;
	end

	always_ff @(posedge clk) begin
		if (!nrst || (ce && txClr)) begin
			txWp_reg <= '0;
			txRp_reg <= '0;
			txCount_reg <= '0;
		end else if (ce) begin
			txWp_reg <= txWp_reg + PW'(txPush);
			txRp_reg <= txRp_reg + PW'(txPop);
			txCount_reg <= txCount_reg + (PW+1)'(txPush) - (PW+1)'(txPop);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || (ce && rxClr)) begin
			rxWp_reg <= '0;
			rxRp_reg <= '0;
			rxCount_reg <= '0;
		end else if (ce) begin
			rxWp_reg <= rxWp_reg + PW'(rxDo & fifoEn);
			rxRp_reg <= rxRp_reg + PW'(rxPop & fifoEn);
			if (!fifoEn)
				rxCount_reg <= rxDo ? (PW+1)'(1) : (rxPop ? '0 : rxCount_reg);
			else
				rxCount_reg <= rxCount_reg + (PW+1)'(rxDo) - (PW+1)'(rxPop);
		end
	end

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			overrun_reg <= 1'b0;
			thrIrq_reg <= 1'b0;
			tmoCnt_reg <= 12'h000;
			irqOut <= 1'b0;
			rdata <= 8'h00;
		end else if (ce) begin
			overrun_reg <= ovrSet | (overrun_reg & ~lsrRead);
			thrIrq_reg <= thrSet | (thrIrq_reg & ~thrWrite &
				~(isrRead & (isrCode == ISR_THR)));
			if (rxPush | rxPop | (rxCount_reg == '0))
				tmoCnt_reg <= 12'h000;
			else if (tick16 & (tmoCnt_reg != tmoLimit))
				tmoCnt_reg <= tmoCnt_reg + 12'h001;
			irqOut <= irqNext;
			if (acc & rd)
				rdata <= rdMux;
		end
	end

	// transmitter sequencing
	always_comb begin
		txState_next = txState_reg;
		txSub_next = txSub_reg;
		txBit_next = txBit_reg;
		txShift_next = txShift_reg;
		txPar_next = txPar_reg;
		txStop2_next = txStop2_reg;
		if (txState_reg != SER_IDLE && tick16)
			txSub_next = txSub_reg + 4'h1;
		case (txState_reg)
			SER_IDLE: if (txPop) begin
				txState_next = SER_START;
				txShift_next = txMem[txRp_reg];
				txPar_next = ~lcrReg[LCR_EVEN];
				txSub_next = 4'h0;
			end
			SER_START: if (txBitEnd) begin
				txState_next = SER_DATA;
				txBit_next = 3'h0;
			end
			SER_DATA: if (txBitEnd) begin
				txShift_next = {1'b0, txShift_reg[7:1]};
				txPar_next = txPar_reg ^ txShift_reg[0];
				txBit_next = txBit_reg + 3'h1;
				txStop2_next = 1'b0;
				if (txBit_reg == dataLast)
					txState_next = lcrReg[LCR_PAR] ? SER_PARITY : SER_STOP;
			end
			SER_PARITY: if (txBitEnd) txState_next = SER_STOP;
			SER_STOP: if (txBitEnd) begin
				if (lcrReg[LCR_STOP] && !txStop2_reg)
					txStop2_next = 1'b1;
				else
					txState_next = SER_IDLE;
			end
			default: txState_next = SER_IDLE;
		endcase
		case (txState_next)
			SER_START: txdNext = 1'b0;
			SER_DATA: txdNext = txShift_next[0];
			SER_PARITY: txdNext = txPar_next;
			default: txdNext = 1'b1;
		endcase
	end

	// receiver sequencing
	always_comb begin
		rxState_next = rxState_reg;
		rxSub_next = rxSub_reg;
		rxBit_next = rxBit_reg;
		rxShift_next = rxShift_reg;
		rxPar_next = rxPar_reg;
		rxPe_next = rxPe_reg;
		if (rxState_reg != SER_IDLE && tick16)
			rxSub_next = rxSub_reg + 4'h1;
		case (rxState_reg)
			SER_IDLE: if (rxPrev_reg && !rxd) begin
				rxState_next = SER_START;
				rxSub_next = 4'h0;
			end
			SER_START: if (tick16 && rxSub_reg == HALF_LAST) begin
				// a glitch shorter than half a bit is dropped here
				rxState_next = rxd ? SER_IDLE : SER_DATA;
				rxSub_next = 4'h0;
				rxBit_next = 3'h0;
				rxPar_next = ~lcrReg[LCR_EVEN];
				rxPe_next = 1'b0;
			end
			SER_DATA: if (rxBitEnd) begin
				rxShift_next = {rxd, rxShift_reg[7:1]};
				rxPar_next = rxPar_reg ^ rxd;
				rxBit_next = rxBit_reg + 3'h1;
				if (rxBit_reg == dataLast)
					rxState_next = lcrReg[LCR_PAR] ? SER_PARITY : SER_STOP;
			end
			SER_PARITY: if (rxBitEnd) begin
				rxPe_next = rxd != rxPar_reg;
				rxState_next = SER_STOP;
			end
			SER_STOP: if (rxBitEnd) rxState_next = SER_IDLE;
			default: rxState_next = SER_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			txState_reg <= SER_IDLE;
			rxState_reg <= SER_IDLE;
			{txSub_reg, rxSub_reg, txBit_reg, rxBit_reg} <= 14'h0000;
			{txShift_reg, rxShift_reg} <= 16'h0000;
			{txPar_reg, rxPar_reg, txStop2_reg, rxPe_reg} <= 4'h0;
			rxPrev_reg <= 1'b1;
			txd <= 1'b1;
		end else if (ce) begin
			txState_reg <= txState_next;
			rxState_reg <= rxState_next;
			{txSub_reg, rxSub_reg} <= {txSub_next, rxSub_next};
			{txBit_reg, rxBit_reg} <= {txBit_next, rxBit_next};
			{txShift_reg, rxShift_reg} <= {txShift_next, rxShift_next};
			{txPar_reg, rxPar_reg} <= {txPar_next, rxPar_next};
			{txStop2_reg, rxPe_reg} <= {txStop2_next, rxPe_next};
			rxPrev_reg <= rxd;
			txd <= txdNext;
		end
	end

	property p_hdx_reset;
		@(posedge clk) !$past(nrst) |-> !hdx;
	endproperty
	a_hdx_reset: assert property (p_hdx_reset) else $error("hdx on after reset");
	property p_presc_div4;
		@(posedge clk) disable iff (!nrst)
		// a rewrite that drops the divide-by-4 may tick early
		preTick && presBy4 |=> (!preTick || !presBy4) [*3];
	endproperty
	a_presc_div4: assert property (p_presc_div4) else $error("prescale gap");
	property p_tx_bit_len;
		@(posedge clk) disable iff (!nrst)
		$past(txState_reg) != SER_IDLE && txState_reg != $past(txState_reg)
			|-> $past(txSub_reg) == SUB_LAST && $past(tick16);
	endproperty
	a_tx_bit_len: assert property (p_tx_bit_len) else $error("bit length");
	property p_start_low;
		@(posedge clk) disable iff (!nrst)
		txState_reg == SER_START |-> !txd;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start not low");
	property p_tx_push;
		@(posedge clk) disable iff (!nrst)
		txPush && !txPop && !txClr |=>
			txCount_reg == $past(txCount_reg) + 1'b1;
	endproperty
	a_tx_push: assert property (p_tx_push) else $error("tx fifo count");
	property p_false_start;
		@(posedge clk) disable iff (!nrst)
		ce && rxState_reg == SER_START && tick16 && rxSub_reg == HALF_LAST
			&& rxd |=> rxState_reg == SER_IDLE;
	endproperty
	a_false_start: assert property (p_false_start) else $error("false start");
	property p_rx_pop;
		@(posedge clk) disable iff (!nrst)
		ce && fifoEn && rxPop && !rxDo && !rxClr |=>
			rxCount_reg == $past(rxCount_reg) - 1'b1;
	endproperty
	a_rx_pop: assert property (p_rx_pop) else $error("rx pop count");
	property p_irq_thr_busy;
		@(posedge clk) disable iff (!nrst)
		ce && !fifoEn && ierReg == 2'h2 && txCount_reg != '0 |=> !irqOut;
	endproperty
	a_irq_thr_busy: assert property (p_irq_thr_busy) else $error("irq high");
	property p_irq_rx_trig;
		@(posedge clk) disable iff (!nrst)
		ce && fifoEn && ierReg == 2'h1 && int'(rxCount_reg) >= int'(rxTrig)
			|=> irqOut;
	endproperty
	a_irq_rx_trig: assert property (p_irq_rx_trig) else $error("irq low");
	c_frame: cover property (@(posedge clk) txState_reg == SER_STOP
		##1 txState_reg == SER_IDLE);
	c_rx_char: cover property (@(posedge clk) rxDo);
	c_timeout: cover property (@(posedge clk) tmoFlag);
	c_rx_full: cover property (@(posedge clk) rxFull);
endmodule // ucsc_channel

// [verification/ucsc_remote.sv]
// remote serial device: drives rxd with frames, samples txd frames
// assumes bitClk is set by the bench to divisor*prescale*16 clk cycles
`timescale 1ns/1ps
module ucsc_remote (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	int bitClk = 32;
	// idle line marks high, as a pulled-up serial line does
	initial rxd = 1'b1;
	// flip corrupts parity on purpose, only when a scenario asks
	task automatic send(input logic [7:0] d, input int nb, input bit par,
		input bit even, input bit flip, input int nStop);
		logic p;
		p = (^(d & (8'hff >> (8 - nb)))) ^ !even ^ flip;
		@(negedge clk) rxd = 1'b0;
		repeat (bitClk) @(negedge clk);
		for (int i = 0; i < nb; i++) begin
			rxd = d[i];
			repeat (bitClk) @(negedge clk);
		end
		if (par) begin
			rxd = p;
			repeat (bitClk) @(negedge clk);
		end
		rxd = 1'b1;
		repeat (nStop * bitClk) @(negedge clk);
	endtask
	// short low pulse, too brief to pass a start check
	task automatic glitch(input int n);
		@(negedge clk) rxd = 1'b0;
		repeat (n) @(negedge clk);
		rxd = 1'b1;
	endtask
	// samples at bit centres counted from the start edge
	task automatic capture(input int nb, input bit par,
		output logic [7:0] d, output logic p, output logic stp);
		int k;
		d = 8'h00;
		p = 1'b0;
		k = 0;
		while (txd !== 1'b0 && k < 100000) begin
			@(negedge clk);
			k++;
		end
		repeat (bitClk / 2) @(negedge clk);
		for (int i = 0; i < nb; i++) begin
			repeat (bitClk) @(negedge clk);
			d[i] = txd;
		end
		if (par) begin
			repeat (bitClk) @(negedge clk);
			p = txd;
		end
		repeat (bitClk) @(negedge clk);
		stp = txd;
	endtask
endmodule // ucsc_remote

// [verification/uart_channel_serial_core_tb.sv]
// self-checking bench for one serial channel with a remote line model
// assumes clk at 200 MHz; fast divisors keep frames short
`timescale 1ns/1ps
module uart_channel_serial_core_tb
	import ucsc_pkg::*;
();
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic cs = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic rxd;
	logic txd;
	logic irqOut;
	int n_fail = 0;
	int compares = 0;
	int seed = 26282;
	int n0, n1;
	logic [7:0] v, d;
	logic [7:0] q[$], e[$];
	logic p, s;
	int divs[3] = '{2, 1, 3};
	bit pres[3] = '{0, 1, 0};
	logic [7:0] fmts[6] = '{8'h03, 8'h1b, 8'h0b, 8'h07, 8'h00, 8'h02};
	always #2.5 clk = ~clk;
	ucsc_channel u_ucsc_channel (.clk(clk), .nrst(nrst), .ce(ce), .cs(cs),
		.rd(rd), .wr(wr), .addr(addr), .wdata(wdata), .rdata(rdata),
		.rxd(rxd), .txd(txd), .irqOut(irqOut));
	ucsc_remote u_ucsc_remote (.clk(clk), .txd(txd), .rxd(rxd));
	function automatic logic [7:0] msk(input logic [7:0] line_ctl_reg);
		return 8'hff >> (3 - line_ctl_reg[1:0]);
	endfunction
	function automatic logic par_of(input logic [7:0] dv, input logic [7:0] line_ctl_reg);
		return (^(dv & msk(line_ctl_reg))) ^ !line_ctl_reg[LCR_EVEN];
	endfunction
	function automatic int bit_len(input int div, input bit pre);
		return div * (pre ? 4 : 1) * SAMPLES;
	endfunction
	function automatic int tmo_clk(input logic [7:0] line_ctl_reg, input int bl);
		int cb;
		cb = 7 + line_ctl_reg[1:0] + line_ctl_reg[LCR_PAR] + line_ctl_reg[LCR_STOP];
		return (TMO_CHARS * cb + TMO_EXTRA) * bl;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] dv);
		@(negedge clk);
		cs = 1'b1;
		wr = 1'b1;
		addr = a;
		wdata = dv;
		@(negedge clk);
		cs = 1'b0;
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] dv);
		@(negedge clk);
		cs = 1'b1;
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		cs = 1'b0;
		rd = 1'b0;
		@(negedge clk);
		dv = rdata;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] r;
		rd_reg(a, r);
		check(r, exp);
	endtask
	task automatic irq_chk(input logic exp);
		check({7'h00, irqOut}, {7'h00, exp});
	endtask
	task automatic set_div(input logic [15:0] dv, input bit pre,
		input logic [7:0] line_ctl_reg);
		wr_reg(ADDR_LCR, 8'h80 | line_ctl_reg);
		wr_reg(ADDR_DATA, dv[7:0]);
		wr_reg(ADDR_IER, dv[15:8]);
		rd_chk(ADDR_DATA, dv[7:0]);
		rd_chk(ADDR_IER, dv[15:8]);
		wr_reg(ADDR_LCR, line_ctl_reg);
		wr_reg(ADDR_MCR, {pre, 7'h00});
		u_ucsc_remote.bitClk = bit_len(dv, pre);
	endtask
	task automatic measure();
		while (txd !== 1'b0) @(negedge clk);
		n0 = 0;
		n1 = 0;
		while (txd === 1'b0) begin
			n0++;
			@(negedge clk);
		end
		while (txd === 1'b1 && n1 < 1000) begin
			n1++;
			@(negedge clk);
		end
	endtask
	task automatic tx_one(input logic [7:0] line_ctl_reg, input logic [7:0] dv);
		fork
			u_ucsc_remote.capture(5 + line_ctl_reg[1:0], line_ctl_reg[LCR_PAR], d, p, s);
			wr_reg(ADDR_DATA, dv);
		join
		check(d, dv & msk(line_ctl_reg));
		if (line_ctl_reg[LCR_PAR]) check({7'h00, p}, {7'h00, par_of(dv, line_ctl_reg)});
		check({7'h00, s}, 8'h01);
	endtask
	task automatic report_and_stop();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		$display("[ERR] t=%0t watchdog expired", $time);
		report_and_stop();
	end
	initial begin
		int bl;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		rd_chk(ADDR_LCR, REG_RST);
		rd_chk(ADDR_MCR, REG_RST);
		rd_chk(ADDR_IER, REG_RST);
		rd_chk(ADDR_ISR_FCR, ISR_NONE);
		rd_chk(ADDR_LSR, 8'h60);
		rd_chk(ADDR_FEAT, REG_RST);
		rd_chk(3'h6, 8'h00);
		irq_chk(1'b0);
		// frozen clock enable must swallow the write
		ce = 1'b0;
		wr_reg(ADDR_DATA, 8'ha5);
		ce = 1'b1;
		rd_chk(ADDR_LSR, 8'h60);
		wr_reg(ADDR_LCR, 8'h80);
		rd_chk(ADDR_DATA, DLL_RST);
		rd_chk(ADDR_IER, REG_RST);
		set_div(16'h0900, 1'b0, 8'h03);
		foreach (divs[i]) begin
			set_div(16'(divs[i]), pres[i], 8'h03);
			bl = u_ucsc_remote.bitClk;
			fork
				measure();
				wr_reg(ADDR_DATA, 8'h55);
			join
			// load is tick aligned, so the start bit is a whole bit
			check(8'(n0), 8'(bl));
			check(8'(n1), 8'(bl));
			repeat (bl * 10) @(negedge clk);
		end
		set_div(16'h0002, 1'b0, 8'h03);
		foreach (fmts[i]) begin
			wr_reg(ADDR_LCR, fmts[i]);
			tx_one(fmts[i], 8'($random(seed)));
			v = 8'($random(seed));
			u_ucsc_remote.send(v, 5 + fmts[i][1:0], fmts[i][LCR_PAR],
				fmts[i][LCR_EVEN], 1'b0, 1 + fmts[i][LCR_STOP]);
			rd_chk(ADDR_LSR, 8'h61);
			rd_reg(ADDR_DATA, d);
			check(d & msk(fmts[i]), v & msk(fmts[i]));
		end
		wr_reg(ADDR_LCR, 8'h03);
		u_ucsc_remote.glitch(8);
		repeat (400) @(negedge clk);
		rd_chk(ADDR_LSR, 8'h60);
		u_ucsc_remote.send(8'h3c, 8, 1'b0, 1'b0, 1'b0, 1);
		u_ucsc_remote.send(8'hc3, 8, 1'b0, 1'b0, 1'b0, 1);
		rd_chk(ADDR_LSR, 8'h63);
		rd_chk(ADDR_DATA, 8'hc3);
		rd_chk(ADDR_LSR, 8'h60);
		wr_reg(ADDR_IER, 8'h02);
		repeat (2) @(negedge clk);
		irq_chk(1'b1);
		for (int h = 0; h < 2; h++) begin
			wr_reg(ADDR_FEAT, h ? 8'h08 : 8'h00);
			wr_reg(ADDR_DATA, 8'h5a);
			repeat (4) @(negedge clk);
			irq_chk(h == 0);
			if (h == 0) rd_chk(ADDR_LSR, 8'h20);
			if (h == 0) rd_chk(ADDR_ISR_FCR, ISR_THR);
			repeat (360) @(negedge clk);
			irq_chk(1'b1);
			rd_chk(ADDR_LSR, 8'h60);
		end
		wr_reg(ADDR_FEAT, 8'h00);
		wr_reg(ADDR_ISR_FCR, 8'h01);
		fork
			for (int i = 0; i < 10; i++) begin
				u_ucsc_remote.capture(8, 1'b0, d, p, s);
				q.push_back(d);
			end
			begin
				for (int i = 0; i < 10; i++) begin
					v = 8'($random(seed));
					e.push_back(v);
					wr_reg(ADDR_DATA, v);
				end
				irq_chk(1'b0);
				rd_chk(ADDR_LSR, 8'h00);
			end
		join
		foreach (e[i]) check(q[i], e[i]);
		repeat (64) @(negedge clk);
		irq_chk(1'b1);
		rd_chk(ADDR_LSR, 8'h60);
		rd_chk(ADDR_ISR_FCR, {ISR_FIFO_ON, ISR_THR[5:0]});
		wr_reg(ADDR_LCR, 8'h1b);
		wr_reg(ADDR_IER, 8'h01);
		// irq output is registered: let the new enable settle first
		@(negedge clk);
		e.delete();
		for (int i = 0; i < 8; i++) begin
			irq_chk(1'b0);
			v = 8'($random(seed));
			e.push_back(v);
			u_ucsc_remote.send(v, 8, 1'b1, 1'b1, i == 3, 1);
		end
		repeat (4) @(negedge clk);
		irq_chk(1'b1);
		foreach (e[i]) begin
			rd_chk(ADDR_LSR, (i == 3) ? 8'h65 : 8'h61);
			rd_chk(ADDR_DATA, e[i]);
		end
		rd_chk(ADDR_LSR, 8'h60);
		irq_chk(1'b0);
		u_ucsc_remote.send(8'h96, 8, 1'b1, 1'b1, 1'b0, 1);
		repeat (tmo_clk(8'h1b, 32) - 90) @(negedge clk);
		irq_chk(1'b0);
		repeat (160) @(negedge clk);
		irq_chk(1'b1);
		rd_chk(ADDR_ISR_FCR, {ISR_FIFO_ON, ISR_TMO[5:0]});
		rd_chk(ADDR_DATA, 8'h96);
		report_and_stop();
	end
endmodule // uart_channel_serial_core_tb
